// ---- inc/hasb_pkg.sv ----
// Purpose: constants for the handler active-status register block
// Assumes: 32-bit APB, one register word
// Notes: offset of the register word is a local choice
package hasb_pkg;
  localparam logic [11:0] HASB_STATE_OFFSET = 12'h000;
  localparam int HASB_PEND_SERVICE_BIT = 10;
  localparam int HASB_DEBUG_MONITOR_BIT = 8;
  localparam int HASB_SUPERVISOR_CALL_BIT = 7;
  localparam int HASB_USAGE_FAULT_BIT = 3;
  localparam int HASB_BUS_FAULT_BIT = 1;
  localparam int HASB_MEM_MANAGE_BIT = 0;
  localparam int HASB_NUM_HANDLERS = 6;
  // writable bit positions of the register word
  localparam logic [31:0] HASB_ACTIVE_MASK = 32'h0000_058b;
  localparam logic [5:0] HASB_ACTIVE_RESET = 6'h00;
  localparam logic [31:0] HASB_READ_ZERO = 32'h0000_0000;
  typedef enum logic [1:0] {
    HASB_IDLE = 2'b01,
    HASB_ACCESS = 2'b10
  } hasb_apb_state_t;
endpackage

// ---- core/hasb_flag_cell.sv ----
// Purpose: one handler active flag with hardware entry/return and software write
// Assumes: entry, return and write are pulses on mclk
// Notes: hardware entry wins over a software clear in the same cycle
`timescale 1ns/1ns
module hasb_flag_cell (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic handlerEntry,
  input wire logic handlerReturn,
  input wire logic swWrite,
  input wire logic swValue,
  output logic flagActive
);
  import hasb_pkg::*;
  logic flag_r;
  logic flag_nxt;

  // entry beats return and software write, so no entry event is lost
  always_comb begin
    flag_nxt = flag_r;
    if (swWrite) begin
      flag_nxt = swValue;
    end
    if (handlerReturn) begin
      flag_nxt = 1'b0;
    end
    if (handlerEntry) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flagActive = flag_r;
endmodule

// ---- core/hasb_active_status.sv ----
// Purpose: APB register holding the six handler active-status flags
// Assumes: APB master per protocol; exception logic gives entry/return pulses
// Notes: zero-wait APB slave; unmapped reads return zero with pslverr
//
// Notes on behaviour
// - pend-service active flag, bit 10, writable
// - debug-monitor active flag, bit 8, writable
// - supervisor-call active flag, bit 7, writable
// - usage-fault active flag, bit 3, writable
// - bus-fault active flag, bit 1, writable
// - mem-manage-fault active flag, bit 0, writable
// - bits 9, 6:4, 2 read zero
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ns
module hasb_active_status (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // one bit per handler in order: pend, monitor, svcall, usage, bus, mem
  input wire logic [5:0] handlerEntry,
  input wire logic [5:0] handlerReturn,
  output logic [5:0] handlerActive
);
  import hasb_pkg::*;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic hitState;
  logic wrStrobe;
  logic [5:0] wrValue;
  logic [31:0] rdWord;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  hasb_apb_state_t apbState_r;
  hasb_apb_state_t apbState_nxt;

  // packs the six flags into their register positions
  function automatic logic [31:0] hasb_pack(input logic [5:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[HASB_PEND_SERVICE_BIT] = f[5];
    w[HASB_DEBUG_MONITOR_BIT] = f[4];
    w[HASB_SUPERVISOR_CALL_BIT] = f[3];
    w[HASB_USAGE_FAULT_BIT] = f[2];
    w[HASB_BUS_FAULT_BIT] = f[1];
    w[HASB_MEM_MANAGE_BIT] = f[0];
    return w;
  endfunction

  assign hitState = (paddr == HASB_STATE_OFFSET);
  // write takes effect only at the completing access edge
  assign wrStrobe = psel && penable && pwrite && hitState;
  assign wrValue = {pwdata[HASB_PEND_SERVICE_BIT], pwdata[HASB_DEBUG_MONITOR_BIT],
                    pwdata[HASB_SUPERVISOR_CALL_BIT], pwdata[HASB_USAGE_FAULT_BIT],
                    pwdata[HASB_BUS_FAULT_BIT], pwdata[HASB_MEM_MANAGE_BIT]};
  // reserved positions never come from storage, so they always read zero
  assign rdWord = hasb_pack(handlerActive) & HASB_ACTIVE_MASK;

  // ----------------------------------------
  // flag storage
  // ----------------------------------------
  // hardware entry/return and software writes per handler
  genvar gi;
  generate
    for (gi = 0; gi < HASB_NUM_HANDLERS; gi = gi + 1) begin : g_flag
      hasb_flag_cell u_cell (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .handlerEntry(handlerEntry[gi]),
        .handlerReturn(handlerReturn[gi]),
        .swWrite(wrStrobe),
        .swValue(wrValue[gi]),
        .flagActive(handlerActive[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // apb phase tracking and read data
  // ----------------------------------------
  // read data is registered in setup so it is stable through access
  always_comb begin
    apbState_nxt = apbState_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    case (apbState_r)
      HASB_IDLE: begin
        if (psel && !penable) begin
          apbState_nxt = HASB_ACCESS;
          prdata_nxt = (hitState && !pwrite) ? rdWord : HASB_READ_ZERO;
          pslverr_nxt = !hitState;
        end
      end
      HASB_ACCESS: begin
        apbState_nxt = HASB_IDLE;
      end
      default: begin
        apbState_nxt = HASB_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      apbState_r <= HASB_IDLE;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      apbState_r <= apbState_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1; // zero wait states
  assign pslverr = pslverr_r & psel & penable;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_reserved_zero;
    @(posedge mclk) disable iff (sys_rst)
      (psel && penable && !pwrite) |-> (prdata & ~HASB_ACTIVE_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");

  property p_pend_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[5] && !handlerReturn[5]) |=> handlerActive[5] == $past(pwdata[10]);
  endproperty
  a_pend_write: assert property (p_pend_write) else $error("pend flag write lost");

  property p_mon_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[4] && !handlerReturn[4]) |=> handlerActive[4] == $past(pwdata[8]);
  endproperty
  a_mon_write: assert property (p_mon_write) else $error("monitor flag write lost");

  property p_svc_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[3] && !handlerReturn[3]) |=> handlerActive[3] == $past(pwdata[7]);
  endproperty
  a_svc_write: assert property (p_svc_write) else $error("svcall flag write lost");

  property p_usage_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[2] && !handlerReturn[2]) |=> handlerActive[2] == $past(pwdata[3]);
  endproperty
  a_usage_write: assert property (p_usage_write) else $error("usage flag write lost");

  property p_bus_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[1] && !handlerReturn[1]) |=> handlerActive[1] == $past(pwdata[1]);
  endproperty
  a_bus_write: assert property (p_bus_write) else $error("bus flag write lost");

  property p_mem_write;
    @(posedge mclk) disable iff (sys_rst)
      (wrStrobe && !handlerEntry[0] && !handlerReturn[0]) |=> handlerActive[0] == $past(pwdata[0]);
  endproperty
  a_mem_write: assert property (p_mem_write) else $error("mem flag write lost");

  property p_entry_sets;
    @(posedge mclk) disable iff (sys_rst)
      handlerEntry[0] |=> handlerActive[0];
  endproperty
  a_entry_sets: assert property (p_entry_sets) else $error("entry did not set flag");

  property p_return_clears;
    @(posedge mclk) disable iff (sys_rst)
      (handlerReturn[2] && !handlerEntry[2]) |=> !handlerActive[2];
  endproperty
  a_return_clears: assert property (p_return_clears) else $error("return did not clear flag");

  property p_read_matches;
    @(posedge mclk) disable iff (sys_rst)
      (psel && !penable && !pwrite && hitState) ##1 (psel && penable)
        |-> prdata[10] == $past(handlerActive[5]) && prdata[0] == $past(handlerActive[0]);
  endproperty
  a_read_matches: assert property (p_read_matches) else $error("read data wrong");

  // whole-vector event checks: a broken bit slice in one cell shows up here, not only on bits 0 and 2
  property p_entry_all;
    @(posedge mclk) disable iff (sys_rst)
      (handlerEntry != 6'h00) |=> ((handlerActive & $past(handlerEntry)) == $past(handlerEntry));
  endproperty
  a_entry_all: assert property (p_entry_all) else $error("entry left a flag clear");

  property p_return_all;
    @(posedge mclk) disable iff (sys_rst)
      (handlerReturn != 6'h00) |=> ((handlerActive & $past(handlerReturn) & ~$past(handlerEntry)) == 6'h00);
  endproperty
  a_return_all: assert property (p_return_all) else $error("return left a flag set");

  property p_quiet_hold;
    @(posedge mclk) disable iff (sys_rst)
      (!wrStrobe && handlerEntry == 6'h00 && handlerReturn == 6'h00) |=> $stable(handlerActive);
  endproperty
  a_quiet_hold: assert property (p_quiet_hold) else $error("flag moved with no event");

  property p_unmapped_read;
    @(posedge mclk) disable iff (sys_rst)
      (psel && penable && !pwrite && !hitState) |-> (prdata == HASB_READ_ZERO) && pslverr;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero with error");

  property p_mapped_no_err;
    @(posedge mclk) disable iff (sys_rst)
      (psel && penable && hitState) |-> !pslverr;
  endproperty
  a_mapped_no_err: assert property (p_mapped_no_err) else $error("mapped access flagged error");
endmodule

// ---- verif/hasb_active_status_tb.sv ----
// Purpose: self-checking bench for the handler active-status register
// Assumes: APB master waits on pready; events are one-cycle pulses
// Notes: one idle cycle between transfers keeps each signal to one update per step
`timescale 1ns/1ns
module hasb_active_status_tb;
  import hasb_pkg::*;
  logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, errVal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdVal;
  logic [5:0] handlerEntry, handlerReturn, handlerActive;
  int failures, checksDone;
  int bitPos [6] = '{HASB_MEM_MANAGE_BIT, HASB_BUS_FAULT_BIT, HASB_USAGE_FAULT_BIT,
    HASB_SUPERVISOR_CALL_BIT, HASB_DEBUG_MONITOR_BIT, HASB_PEND_SERVICE_BIT};
  hasb_active_status uut (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .handlerEntry(handlerEntry), .handlerReturn(handlerReturn),
    .handlerActive(handlerActive));
  // -----------------------------------------------
  // tasks
  // -----------------------------------------------
  task automatic complete_run();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // setup then access; request held until the rising edge that sees pready high, data taken there
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      complete_run();
    end else begin
      rdVal = prdata;
      errVal = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task automatic pulse(input logic [5:0] ent, input logic [5:0] ret);
    handlerEntry <= ent;
    handlerReturn <= ret;
    @(posedge mclk);
    handlerEntry <= 6'h00;
    handlerReturn <= 6'h00;
    @(posedge mclk);
  endtask
  // expected register word from the six flags, reserved places zero
  function automatic logic [31:0] toWord(input logic [5:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 6; i++) w[bitPos[i]] = f[i];
    return w;
  endfunction
  // -----------------------------------------------
  // stimulus
  // -----------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    handlerEntry = 6'h00;
    handlerReturn = 6'h00;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    check("active after reset", {26'h0, handlerActive}, {26'h0, HASB_ACTIVE_RESET});
    apb(1'b0, HASB_STATE_OFFSET, 32'h0);
    check("word after reset", rdVal, 32'h0);
    check("mapped error flag", {31'h0, errVal}, 32'h0);
    // forcing every flag at once; reserved places must stay zero
    apb(1'b1, HASB_STATE_OFFSET, 32'hffff_ffff);
    apb(1'b0, HASB_STATE_OFFSET, 32'h0);
    check("all set word", rdVal, 32'h0000_058b);
    // each flag alone, written by software
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, HASB_STATE_OFFSET, toWord(6'h01 << i));
      check("single flag", {26'h0, handlerActive}, 32'h1 << i);
      apb(1'b0, HASB_STATE_OFFSET, 32'h0);
      check("single word", rdVal, 32'h1 << bitPos[i]);
    end
    // read-modify-write keeps what was read in reserved places
    apb(1'b1, HASB_STATE_OFFSET, rdVal & 32'hffff_fa74);
    check("cleared by write", {26'h0, handlerActive}, 32'h0);
    // hardware entry and return per handler
    for (int i = 0; i < 6; i++) begin
      pulse(6'h01 << i, 6'h00);
      apb(1'b0, HASB_STATE_OFFSET, 32'h0);
      check("entry word", rdVal, 32'h1 << bitPos[i]);
      pulse(6'h00, 6'h01 << i);
      check("after return", {26'h0, handlerActive}, 32'h0);
    end
    pulse(6'h3f, 6'h3f);
    check("entry beats return", {26'h0, handlerActive}, 32'h3f);
    // unmapped place: write ignored, reads zero with error
    apb(1'b1, 12'h004, 32'h0000_0000);
    check("unmapped write err", {31'h0, errVal}, 32'h1);
    check("unmapped write kept", {26'h0, handlerActive}, 32'h3f);
    apb(1'b0, 12'h004, 32'h0);
    check("unmapped read", rdVal, 32'h0);
    check("unmapped read err", {31'h0, errVal}, 32'h1);
    // reset in mid-run must drop every flag that entry left set
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    check("active after second reset", {26'h0, handlerActive}, {26'h0, HASB_ACTIVE_RESET});
    apb(1'b0, HASB_STATE_OFFSET, 32'h0);
    check("word after second reset", rdVal, 32'h0);
    complete_run();
  end
endmodule
